// File: pkg/mdpc_defines.vh
// Register offsets, field positions, reset values and timing figures of the motion detect block
`ifndef MDPC_DEFINES_VH
`define MDPC_DEFINES_VH

// Register offsets on the serial register port
`define MDPC_ADDR_X_OFFSET 6'h1e
`define MDPC_ADDR_Y_OFFSET 6'h1f
`define MDPC_ADDR_Z_OFFSET 6'h20
`define MDPC_ADDR_ACT_THR 6'h24
`define MDPC_ADDR_INACT_THR 6'h25
`define MDPC_ADDR_INACT_TIME 6'h26
`define MDPC_ADDR_MOTION_CTL 6'h27
`define MDPC_ADDR_RATE 6'h2c
`define MDPC_ADDR_POWER 6'h2d
`define MDPC_ADDR_DATA_FIRST 6'h32
`define MDPC_ADDR_DATA_LAST 6'h37

// Motion detect control fields
`define MDPC_ACT_COUPLING_BIT 7
`define MDPC_ACT_AXES_HI 6
`define MDPC_ACT_AXES_LO 4
`define MDPC_INACT_COUPLING_BIT 3
`define MDPC_INACT_AXES_HI 2
`define MDPC_INACT_AXES_LO 0

// Rate and power select fields
`define MDPC_RATE_LOWPWR_BIT 4
`define MDPC_RATE_CODE_HI 3
`define MDPC_RATE_WRITE_MASK 8'h1f
`define MDPC_RATE_RESET 8'h0a

// Power mode control fields
`define MDPC_PWR_SERIAL_DIS_BIT 6
`define MDPC_PWR_LINK_BIT 5
`define MDPC_PWR_AUTOSLEEP_BIT 4
`define MDPC_PWR_MEASURE_BIT 3
`define MDPC_PWR_SLEEP_BIT 2
`define MDPC_PWR_WAKE_HI 1
`define MDPC_PWR_WRITE_MASK 8'h7f
`define MDPC_PWR_RESET 8'h00
`define MDPC_CFG_RESET 8'h00

// Scaling of offset and thresholds into sample units (1024 LSB per g)
`define MDPC_OFFSET_SHIFT 2
`define MDPC_THRESH_SHIFT 4

// Timing: clock rate and the fastest wake-up tick
`define MDPC_CLK_KHZ 100000
`define MDPC_WAKE_TICK_MS 125
`define MDPC_TICKS_PER_SEC 8

`endif

// File: core/mdpc_tick_div.v
// Cycle divider that issues a one-cycle enable pulse every COUNT cycles
`timescale 1ns/1ps
module mdpc_tick_div #(
   parameter COUNT = 12500000
) (
   input wire clk,
   input wire rst_n,
   output reg tick
);
   reg [31:0] count;

   // Free running counter, pulse on wrap
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 32'h0;
         tick <= 1'b0;
      end else if (count == COUNT - 1) begin
         count <= 32'h0;
         tick <= 1'b1;
      end else begin
         count <= count + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule // mdpc_tick_div

// File: core/mdpc_axis_cmp.v
// One-axis magnitude compare against a threshold, dc or ac coupled
`timescale 1ns/1ps
`include "mdpc_defines.vh"
module mdpc_axis_cmp (
   input wire [15:0] sample,
   input wire [15:0] refValue,
   input wire acMode,
   input wire [7:0] threshold,
   output wire above,
   output wire below
);
   // Absolute value of a signed 17-bit quantity
   function [16:0] absVal;
      input [16:0] v;
      begin
         absVal = v[16] ? (~v + 17'h1) : v;
      end
   endfunction

   wire [16:0] sampleExt;
   wire [16:0] refExt;
   wire [16:0] magnitude;
   wire [16:0] limit;

   // Magnitude is the sample itself or its distance to the reference
   assign sampleExt = {sample[15], sample};
   assign refExt = {refValue[15], refValue};
   assign magnitude = acMode ? absVal(sampleExt - refExt) : absVal(sampleExt);
   assign limit = {5'h0, threshold, 4'h0};
   assign above = magnitude > limit;
   assign below = magnitude < limit;
endmodule // mdpc_axis_cmp

// File: core/mdpc_motion_ctrl.v
// Motion detect and power control: serial register port, offsets, activity and inactivity
`timescale 1ns/1ps
`include "mdpc_defines.vh"
module mdpc_motion_ctrl #(
   parameter WAKE_TICK_CYCLES = `MDPC_WAKE_TICK_MS * `MDPC_CLK_KHZ
) (
   input wire core_clk,
   input wire rst_n,
   input wire spiCs_n,
   input wire spiSclk,
   input wire spiMosi,
   input wire i2cSda,
   input wire sampleValid,
   input wire [47:0] rawSample,
   input wire [47:0] filteredSample,
   output reg spiMiso,
   output reg spiMisoOe_n,
   output reg [47:0] outData,
   output reg dataReady,
   output reg bufferWrite,
   output reg activityEvent,
   output reg inactivityEvent,
   output reg wakeSample,
   output reg i2cStartSeen,
   output reg [7:0] rateSelect,
   output reg [7:0] powerControl
);
   localparam PH_INACT = 2'b01;
   localparam PH_ACT = 2'b10;

   // Sign-extended offset in sample units added to a sample
   function [15:0] addOffset;
      input [15:0] s;
      input [7:0] ofs;
      begin
         addOffset = s + {{6{ofs[7]}}, ofs, 2'b00};
      end
   endfunction

   reg rstMeta_n;
   reg rstSync_n;
   reg [3:0] pinMeta;
   reg [3:0] pinSync;
   reg sclkPrev;
   reg sdaPrev;
   reg [2:0] bitCount;
   reg firstByte;
   reg isRead;
   reg multiByte;
   reg [5:0] regAddr;
   reg [6:0] shiftIn;
   reg [7:0] shiftOut;
   reg wrStrobe;
   reg [5:0] wrAddr;
   reg [7:0] wrData;
   reg [7:0] xOffset;
   reg [7:0] yOffset;
   reg [7:0] zOffset;
   reg [7:0] actThreshold;
   reg [7:0] inactThreshold;
   reg [7:0] inactTime;
   reg [7:0] motionControl;
   reg [1:0] phase;
   reg actRefValid;
   reg inactRefValid;
   reg [47:0] actRef;
   reg [47:0] inactRef;
   reg [7:0] quietSeconds;
   reg quietSeen;
   reg [3:0] quietEighths;
   reg inactFired;
   reg wakePending;
   reg [2:0] eighthCount;

   wire tick8;
   wire csS_n;
   wire sclkS;
   wire mosiS;
   wire sdaS;
   wire sclkRise;
   wire sclkFall;
   wire [7:0] byteIn;
   wire [5:0] nextAddr;
   wire [47:0] actSample;
   wire [47:0] inactSample;
   wire [2:0] actAbove;
   wire [2:0] inactAbove;
   wire [2:0] inactBelow;
   wire [2:0] actAxes;
   wire [2:0] inactAxes;
   wire measure;
   wire sleep;
   wire linkOn;
   wire bothOn;
   wire actRun;
   wire inactRun;
   wire process;
   wire actHit;
   wire inactHit;
   wire inactReset;
   wire allQuiet;
   wire [2:0] wakeMask;
   wire wakeTick;
   wire secTick;
   wire [7:0] readValue;

   // Reset release through two flip-flops
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   // Pin synchronisers: chip select, serial clock, data in, I2C data
   always @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         pinMeta <= 4'hf;
         pinSync <= 4'hf;
         sclkPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         pinMeta <= {i2cSda, spiMosi, spiSclk, spiCs_n};
         pinSync <= pinMeta;
         sclkPrev <= pinSync[1];
         sdaPrev <= pinSync[3];
      end
   end

   assign csS_n = pinSync[0];
   assign sclkS = pinSync[1];
   assign mosiS = pinSync[2];
   assign sdaS = pinSync[3];
   assign sclkRise = sclkS & ~sclkPrev;
   assign sclkFall = ~sclkS & sclkPrev;
   assign byteIn = {shiftIn, mosiS};
   assign nextAddr = regAddr + {5'h0, multiByte};

   // Readback mux; fixed-zero bits already held at zero in storage
   function [7:0] readMux;
      input [5:0] a;
      begin
         case (a)
            `MDPC_ADDR_X_OFFSET: readMux = xOffset;
            `MDPC_ADDR_Y_OFFSET: readMux = yOffset;
            `MDPC_ADDR_Z_OFFSET: readMux = zOffset;
            `MDPC_ADDR_ACT_THR: readMux = actThreshold;
            `MDPC_ADDR_INACT_THR: readMux = inactThreshold;
            `MDPC_ADDR_INACT_TIME: readMux = inactTime;
            `MDPC_ADDR_MOTION_CTL: readMux = motionControl;
            `MDPC_ADDR_RATE: readMux = rateSelect;
            `MDPC_ADDR_POWER: readMux = powerControl;
            6'h32: readMux = outData[7:0];
            6'h33: readMux = outData[15:8];
            6'h34: readMux = outData[23:16];
            6'h35: readMux = outData[31:24];
            6'h36: readMux = outData[39:32];
            6'h37: readMux = outData[47:40];
            default: readMux = 8'h00;
         endcase
      end
   endfunction

   assign readValue = readMux(firstByte ? byteIn[5:0] : nextAddr);

   // Serial slave, clock idle high, data taken on rising and shifted on falling edges
   always @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         bitCount <= 3'h0;
         firstByte <= 1'b1;
         isRead <= 1'b0;
         multiByte <= 1'b0;
         regAddr <= 6'h00;
         shiftIn <= 7'h00;
         shiftOut <= 8'h00;
         wrStrobe <= 1'b0;
         wrAddr <= 6'h00;
         wrData <= 8'h00;
         spiMiso <= 1'b0;
         spiMisoOe_n <= 1'b1;
      end else begin
         wrStrobe <= 1'b0;
         if (csS_n) begin
            bitCount <= 3'h0;
            firstByte <= 1'b1;
            spiMisoOe_n <= 1'b1;
         end else begin
            if (sclkRise) begin
               shiftIn <= byteIn[6:0];
               bitCount <= bitCount + 3'h1;
               if (bitCount == 3'h7) begin
                  if (firstByte) begin
                     firstByte <= 1'b0;
                     isRead <= byteIn[7];
                     multiByte <= byteIn[6];
                     regAddr <= byteIn[5:0];
                  end else begin
                     regAddr <= nextAddr;
                     if (!isRead) begin
                        wrStrobe <= 1'b1;
                        wrAddr <= regAddr;
                        wrData <= byteIn;
                     end
                  end
                  shiftOut <= readValue;
               end
            end
            if (sclkFall) begin
               spiMiso <= shiftOut[7];
               shiftOut <= {shiftOut[6:0], 1'b0};
               spiMisoOe_n <= ~(isRead & ~firstByte);
            end
         end
      end
   end

   // Start condition on the I2C pins: data falls while clock high and chip select idle
   always @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         i2cStartSeen <= 1'b0;
      end else begin
         i2cStartSeen <= csS_n & sclkS & sdaPrev & ~sdaS
                         & ~powerControl[`MDPC_PWR_SERIAL_DIS_BIT];
      end
   end

   assign measure = powerControl[`MDPC_PWR_MEASURE_BIT];
   assign sleep = powerControl[`MDPC_PWR_SLEEP_BIT];
   assign linkOn = powerControl[`MDPC_PWR_LINK_BIT];
   assign actAxes = motionControl[`MDPC_ACT_AXES_HI:`MDPC_ACT_AXES_LO];
   assign inactAxes = motionControl[`MDPC_INACT_AXES_HI:`MDPC_INACT_AXES_LO];
   assign bothOn = (|actAxes) & (|inactAxes);

   // Wake-up and one-second ticks from an eighth-second divider
   mdpc_tick_div #(
      .COUNT(WAKE_TICK_CYCLES)
   ) wakeDiv (
      .clk(core_clk),
      .rst_n(rstSync_n),
      .tick(tick8)
   );

   always @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         eighthCount <= 3'h0;
      end else if (tick8) begin
         eighthCount <= eighthCount + 3'h1;
      end
   end

   assign wakeMask = (3'h1 << powerControl[`MDPC_PWR_WAKE_HI:0]) - 3'h1;
   assign wakeTick = tick8 & ((eighthCount & wakeMask) == wakeMask);
   assign secTick = tick8 & quietSeen & (quietEighths == `MDPC_TICKS_PER_SEC);

   // Samples are taken in measurement mode; in sleep only at the wake-up rate
   assign process = measure & sampleValid & (~sleep | wakePending);

   // Offset-corrected raw samples for activity, filtered ones for inactivity
   genvar ax;
   generate
      for (ax = 0; ax < 3; ax = ax + 1) begin : axisGen
         assign actSample[16*ax+15:16*ax] = addOffset(rawSample[16*ax+15:16*ax],
            ax == 0 ? xOffset : (ax == 1 ? yOffset : zOffset));
         assign inactSample[16*ax+15:16*ax] = addOffset(filteredSample[16*ax+15:16*ax],
            ax == 0 ? xOffset : (ax == 1 ? yOffset : zOffset));
         mdpc_axis_cmp actCmp (
            .sample(actSample[16*ax+15:16*ax]),
            .refValue(actRef[16*ax+15:16*ax]),
            .acMode(motionControl[`MDPC_ACT_COUPLING_BIT]),
            .threshold(actThreshold),
            .above(actAbove[ax]),
            .below()
         );
         mdpc_axis_cmp inactCmp (
            .sample(inactSample[16*ax+15:16*ax]),
            .refValue(inactRef[16*ax+15:16*ax]),
            .acMode(motionControl[`MDPC_INACT_COUPLING_BIT]),
            .threshold(inactThreshold),
            .above(inactAbove[ax]),
            .below(inactBelow[ax])
         );
      end
   endgenerate

   // Which detectors run: linked search alternates, otherwise both run, inactivity only outside sleep
   assign actRun = (|actAxes) & (~(linkOn & bothOn) | phase == PH_ACT);
   assign inactRun = (|inactAxes) & ~sleep
                     & (~(linkOn & bothOn) | phase == PH_INACT);

   // Activity: any axis above; ac mode waits for its reference
   assign actHit = process & actRun & (|(actAbove & actAxes))
                   & (~motionControl[`MDPC_ACT_COUPLING_BIT] | actRefValid);

   // Inactivity: all participating axes below, held for the inactivity time
   assign inactReset = (|(inactAbove & inactAxes))
                       | (motionControl[`MDPC_INACT_COUPLING_BIT] & ~inactRefValid);
   assign allQuiet = &(inactBelow | ~inactAxes);
   assign inactHit = process & inactRun & ~inactReset & allQuiet & ~inactFired
                     & (quietSeconds >= inactTime);

   // Detector state: references, quiet time and link phase
   always @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         phase <= PH_INACT;
         actRefValid <= 1'b0;
         inactRefValid <= 1'b0;
         actRef <= 48'h0;
         inactRef <= 48'h0;
         quietSeconds <= 8'h00;
         quietEighths <= 4'h0;
         quietSeen <= 1'b0;
         inactFired <= 1'b0;
      end else begin
         if (!measure || !actRun) begin
            actRefValid <= 1'b0;
         end else if (process && !actRefValid) begin
            actRef <= actSample;
            actRefValid <= 1'b1;
         end
         if (!measure || !inactRun) begin
            inactRefValid <= 1'b0;
            quietEighths <= 4'h0;
            quietSeconds <= 8'h00;
            quietSeen <= 1'b0;
            inactFired <= 1'b0;
         end else if (process && (inactReset || !allQuiet)) begin
            inactRef <= inactReset ? inactSample : inactRef;
            inactRefValid <= 1'b1;
            quietEighths <= 4'h0;
            quietSeconds <= 8'h00;
            quietSeen <= 1'b0;
            inactFired <= 1'b0;
         end else begin
            if (process) begin
               quietSeen <= 1'b1;
            end
            if (inactHit) begin
               inactFired <= 1'b1;
            end
            // First second waits one extra tick so a quiet spell is never counted short
            if (tick8 && quietSeen) begin
               quietEighths <= secTick ? 4'h1 : quietEighths + 4'h1;
            end
            if (secTick && quietSeconds != 8'hff) begin
               quietSeconds <= quietSeconds + 8'h01;
            end
         end
         if (!(linkOn && bothOn)) begin
            phase <= PH_INACT;
         end else begin
            case (phase)
               PH_INACT: phase <= inactHit ? PH_ACT : PH_INACT;
               PH_ACT: phase <= actHit ? PH_INACT : PH_ACT;
               default: phase <= PH_INACT;
            endcase
         end
      end
   end

   // Output data registers, data ready, buffer writes and event pulses
   always @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         outData <= 48'h0;
         dataReady <= 1'b0;
         bufferWrite <= 1'b0;
         activityEvent <= 1'b0;
         inactivityEvent <= 1'b0;
         wakeSample <= 1'b0;
         wakePending <= 1'b0;
      end else begin
         if (process) begin
            outData <= inactSample; // unread samples are overwritten
         end
         dataReady <= process & ~sleep;
         bufferWrite <= process & ~sleep;
         activityEvent <= actHit;
         inactivityEvent <= inactHit;
         wakeSample <= measure & sleep & wakeTick;
         if (wakeTick & sleep) begin
            wakePending <= 1'b1;
         end else if (process | ~sleep) begin
            wakePending <= 1'b0;
         end
      end
   end

   // Register file; hardware sleep entry wins over a host write in the same cycle
   always @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         xOffset <= `MDPC_CFG_RESET;
         yOffset <= `MDPC_CFG_RESET;
         zOffset <= `MDPC_CFG_RESET;
         actThreshold <= `MDPC_CFG_RESET;
         inactThreshold <= `MDPC_CFG_RESET;
         inactTime <= `MDPC_CFG_RESET;
         motionControl <= `MDPC_CFG_RESET;
         rateSelect <= `MDPC_RATE_RESET;
         powerControl <= `MDPC_PWR_RESET;
      end else begin
         if (wrStrobe) begin
            case (wrAddr)
               `MDPC_ADDR_X_OFFSET: xOffset <= wrData;
               `MDPC_ADDR_Y_OFFSET: yOffset <= wrData;
               `MDPC_ADDR_Z_OFFSET: zOffset <= wrData;
               `MDPC_ADDR_ACT_THR: actThreshold <= wrData;
               `MDPC_ADDR_INACT_THR: inactThreshold <= wrData;
               `MDPC_ADDR_INACT_TIME: inactTime <= wrData;
               `MDPC_ADDR_MOTION_CTL: motionControl <= wrData;
               `MDPC_ADDR_RATE: rateSelect <= wrData & `MDPC_RATE_WRITE_MASK;
               `MDPC_ADDR_POWER: powerControl <= wrData & `MDPC_PWR_WRITE_MASK;
               default: rateSelect <= rateSelect;
            endcase
         end
         if (inactHit && linkOn && powerControl[`MDPC_PWR_AUTOSLEEP_BIT]) begin
            powerControl[`MDPC_PWR_SLEEP_BIT] <= 1'b1;
         end else if (actHit && linkOn && powerControl[`MDPC_PWR_AUTOSLEEP_BIT]) begin
            powerControl[`MDPC_PWR_SLEEP_BIT] <= 1'b0;
         end
      end
   end
endmodule // mdpc_motion_ctrl

// File: bench/mdpc_host_model.sv
// Host processor model driving the serial register port and the I2C data line
`timescale 1ns/1ps
module mdpc_host_model (
   output logic spiCs_n,
   output logic spiSclk,
   output logic spiMosi,
   output logic i2cSda,
   input wire logic spiMiso
);
   // Idle bus: deselected, clock parked high, data line pulled up
   initial begin
      spiCs_n = 1'b1;
      spiSclk = 1'b1;
      spiMosi = 1'b0;
      i2cSda = 1'b1;
   end

   // One frame of header and data byte, mode 3, MSB first, 125 ns bit period
   task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {hdr, wd};
      rd = 8'h00;
      spiCs_n = 1'b0;
      #62.5;
      for (int i = 15; i >= 0; i--) begin
         spiSclk = 1'b0;
         spiMosi = sh[i];
         #62.5;
         if (i < 8) rd[i] = spiMiso;
         spiSclk = 1'b1;
         #62.5;
      end
      spiCs_n = 1'b1;
      spiMosi = ~spiMosi; // Released line never shows the last bit
      #500;
   endtask

   // Data falls while the clock idles high: looks like a start condition
   task automatic i2c_start();
      i2cSda = 1'b0;
      #200;
      i2cSda = 1'b1;
   endtask
endmodule // mdpc_host_model

// File: bench/mdpc_motion_ctrl_monitor.sv
// Port checker for the motion detect and power control block
`timescale 1ns/1ps
module mdpc_motion_ctrl_monitor #(
   parameter WAKE_TICK_CYCLES = 50
) (
   input wire core_clk,
   input wire rst_n,
   input wire sampleValid,
   input wire [47:0] outData,
   input wire dataReady,
   input wire bufferWrite,
   input wire activityEvent,
   input wire inactivityEvent,
   input wire wakeSample,
   input wire i2cStartSeen,
   input wire [7:0] rateSelect,
   input wire [7:0] powerControl
);
   // All checks run on the core clock and pause during reset
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_rate_zero_bits: assert property (rateSelect[7:5] == 3'h0)
      else $error("Rate register fixed bits not zero");
   a_power_zero_bit: assert property (powerControl[7] == 1'b0)
      else $error("Power register fixed bit not zero");
   a_buffer_follows_ready: assert property (bufferWrite == dataReady)
      else $error("Buffer write differs from data ready");
   a_sleep_no_ready: assert property (dataReady |-> !$past(powerControl[2]))
      else $error("Data ready raised in sleep");
   a_standby_refuses: assert property (sampleValid && !powerControl[3]
      |=> !dataReady && $stable(outData))
      else $error("Sample taken in standby");
   a_data_needs_sample: assert property (!$stable(outData)
      |-> $past(sampleValid) && $past(powerControl[3]))
      else $error("Output data changed without a sample");
   a_event_needs_sample: assert property ((activityEvent || inactivityEvent)
      |-> $past(sampleValid) && $past(powerControl[3]))
      else $error("Motion event without a sample");
   a_sleep_no_inact: assert property (inactivityEvent |-> !$past(powerControl[2]))
      else $error("Inactivity reported in sleep");
   a_sleep_entry: assert property (inactivityEvent && powerControl[5] && powerControl[4]
      |-> ##[0:2] powerControl[2])
      else $error("No sleep after linked inactivity");
   a_i2c_blocked: assert property (i2cStartSeen |-> !powerControl[6])
      else $error("Start condition seen while disabled");
   a_wake_in_sleep: assert property (wakeSample
      |-> $past(powerControl[2] && powerControl[3]))
      else $error("Wake sample outside measured sleep");
endmodule // mdpc_motion_ctrl_monitor
bind mdpc_motion_ctrl mdpc_motion_ctrl_monitor #(.WAKE_TICK_CYCLES(WAKE_TICK_CYCLES)) u_monitor (
   .core_clk(core_clk), .rst_n(rst_n), .sampleValid(sampleValid), .outData(outData),
   .dataReady(dataReady), .bufferWrite(bufferWrite), .activityEvent(activityEvent),
   .inactivityEvent(inactivityEvent), .wakeSample(wakeSample), .i2cStartSeen(i2cStartSeen),
   .rateSelect(rateSelect), .powerControl(powerControl)
);

// File: bench/mdpc_motion_ctrl_tb.sv
// Self-checking testbench of the motion detect and power control block
`timescale 1ns/1ps
`include "mdpc_defines.vh"
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin nMismatch++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module mdpc_motion_ctrl_tb;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic sampleValid = 1'b0;
   logic [47:0] rawSample = 48'h0;
   logic [47:0] filteredSample = 48'h0;
   wire spiCs_n, spiSclk, spiMosi, i2cSda, spiMiso, spiMisoOe_n, dataReady, bufferWrite;
   wire activityEvent, inactivityEvent, wakeSample, i2cStartSeen;
   wire [47:0] outData;
   wire [7:0] rateSelect, powerControl;
   wire misoLine = spiMisoOe_n ? 1'b1 : spiMiso; // Pulled up while not driven
   int nMismatch = 0;
   int nTests = 0;
   logic [7:0] r;
   logic [2:0] s;
   logic hit, rdySeen, actSeen;

   mdpc_motion_ctrl #(.WAKE_TICK_CYCLES(50)) dut (.core_clk(core_clk), .rst_n(rst_n),
      .spiCs_n(spiCs_n), .spiSclk(spiSclk), .spiMosi(spiMosi), .i2cSda(i2cSda),
      .sampleValid(sampleValid), .rawSample(rawSample), .filteredSample(filteredSample),
      .spiMiso(spiMiso), .spiMisoOe_n(spiMisoOe_n), .outData(outData), .dataReady(dataReady),
      .bufferWrite(bufferWrite), .activityEvent(activityEvent),
      .inactivityEvent(inactivityEvent), .wakeSample(wakeSample),
      .i2cStartSeen(i2cStartSeen), .rateSelect(rateSelect), .powerControl(powerControl));
   mdpc_host_model host (.spiCs_n(spiCs_n), .spiSclk(spiSclk), .spiMosi(spiMosi),
      .i2cSda(i2cSda), .spiMiso(misoLine));

   // 100 MHz core clock
   initial begin
      forever #5 core_clk = ~core_clk;
   end

   // Register access over the serial port
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] x;
      host.xfer({2'b00, a}, d, x);
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      host.xfer({2'b10, a}, 8'h00, d);
   endtask

   // One sample pulse; ready and event pulses are taken one cycle later
   task automatic samp(input logic [47:0] raw, input logic [47:0] filt);
      @(negedge core_clk);
      sampleValid = 1'b1;
      rawSample = raw;
      filteredSample = filt;
      @(negedge core_clk);
      sampleValid = 1'b0;
      s = {dataReady, activityEvent, inactivityEvent};
   endtask

   // Start condition on the pins, watching for the detector pulse
   task automatic i2c_try();
      hit = 1'b0;
      fork
         host.i2c_start();
         repeat (40) @(negedge core_clk) if (i2cStartSeen === 1'b1) hit = 1'b1;
      join
   endtask

   // Verdict and end of run
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", nTests, nMismatch);
      if (nMismatch == 0 && nTests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog against a hung run
   initial begin
      #600000;
      nMismatch++;
      conclude();
   end

   // Main sequence
   initial begin
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (8) @(negedge core_clk);
      `CHK("rateSelect", 8'h0a, rateSelect)
      `CHK("powerControl", 8'h00, powerControl)
      rd(`MDPC_ADDR_RATE, r);
      `CHK("rate read", 8'h0a, r)
      wr(`MDPC_ADDR_RATE, 8'hff);
      `CHK("rate fixed bits", 8'h1f, rateSelect)
      `CHK("low power bit", 1'b1, rateSelect[4])
      wr(`MDPC_ADDR_POWER, 8'h80);
      rd(`MDPC_ADDR_POWER, r);
      `CHK("power fixed bit", 8'h00, r)
      rd(6'h21, r);
      `CHK("unmapped read", 8'h00, r)
      samp(48'h0, 48'h0);
      `CHK("standby ready", 1'b0, s[2])
      wr(`MDPC_ADDR_X_OFFSET, 8'h7f);
      wr(`MDPC_ADDR_Y_OFFSET, 8'h80);
      wr(`MDPC_ADDR_Z_OFFSET, 8'h01);
      rd(`MDPC_ADDR_Y_OFFSET, r);
      `CHK("offset read", 8'h80, r)
      wr(`MDPC_ADDR_POWER, 8'h08);
      samp(48'h0, {16'd5, 16'd0, 16'd100});
      `CHK("outData", {16'd9, 16'hfe00, 16'd608}, outData)
      rd(`MDPC_ADDR_DATA_FIRST, r);
      `CHK("data x low", 8'h60, r)
      rd(`MDPC_ADDR_DATA_FIRST + 6'h3, r);
      `CHK("data y high", 8'hfe, r)
      for (int i = 0; i < 3; i++) wr(`MDPC_ADDR_X_OFFSET + 6'(i), 8'h00);
      wr(`MDPC_ADDR_ACT_THR, 8'h02);
      wr(`MDPC_ADDR_INACT_THR, 8'h01);
      wr(`MDPC_ADDR_MOTION_CTL, 8'h77);
      samp({32'h0, 16'd33}, 48'h0);
      `CHK("both concurrent", 3'b111, s)
      samp({32'h0, 16'd32}, 48'h0);
      `CHK("at act threshold", 3'b100, s)
      samp({-16'sd33, 32'h0}, {16'h0, 16'd16, 16'h0});
      `CHK("z negative above", 3'b110, s)
      samp(48'h0, 48'h0);
      `CHK("quiet time zero", 3'b101, s)
      wr(`MDPC_ADDR_MOTION_CTL, 8'h07);
      samp({32'h0, 16'd100}, 48'h0);
      `CHK("axes excluded", 3'b100, s)
      wr(`MDPC_ADDR_MOTION_CTL, 8'hf0);
      samp({32'h0, 16'd1000}, 48'h0);
      `CHK("ac reference", 3'b100, s)
      samp({32'h0, 16'd1020}, 48'h0);
      `CHK("ac small step", 3'b100, s)
      samp({32'h0, 16'd1040}, 48'h0);
      `CHK("ac large step", 3'b110, s)
      wr(`MDPC_ADDR_MOTION_CTL, 8'h07);
      wr(`MDPC_ADDR_INACT_TIME, 8'h01);
      samp(48'h0, {16'h0, 16'd100, 16'h0});
      samp(48'h0, 48'h0);
      `CHK("quiet first", 1'b0, s[0])
      repeat (300) @(negedge core_clk);
      samp(48'h0, 48'h0);
      `CHK("quiet short", 1'b0, s[0])
      repeat (200) @(negedge core_clk);
      samp(48'h0, 48'h0);
      `CHK("quiet one second", 1'b1, s[0])
      wr(`MDPC_ADDR_INACT_TIME, 8'h00);
      wr(`MDPC_ADDR_MOTION_CTL, 8'h0f);
      samp(48'h0, {16'h0, 16'd500, 16'h0});
      `CHK("ac inact refresh", 1'b0, s[0])
      samp(48'h0, {16'h0, 16'd510, 16'h0});
      `CHK("ac inact quiet", 1'b1, s[0])
      wr(`MDPC_ADDR_MOTION_CTL, 8'h77);
      wr(`MDPC_ADDR_POWER, 8'h00); // Standby restarts detection from a clean state
      wr(`MDPC_ADDR_POWER, 8'h39);
      samp({32'h0, 16'd100}, 48'h0);
      `CHK("linked first", 2'b01, s[1:0])
      `CHK("auto sleep", 1'b1, powerControl[2])
      rdySeen = 1'b0;
      actSeen = 1'b0;
      for (int i = 0; i < 100 && !actSeen; i++) begin
         samp({32'h0, 16'd100}, 48'h0);
         rdySeen = rdySeen | s[2];
         actSeen = s[1];
      end
      `CHK("sleep ready", 1'b0, rdySeen)
      `CHK("sleep activity", 1'b1, actSeen)
      wr(`MDPC_ADDR_POWER, 8'h00);
      wr(`MDPC_ADDR_POWER, 8'h08);
      i2c_try();
      `CHK("start seen", 1'b1, hit)
      wr(`MDPC_ADDR_POWER, 8'h48);
      i2c_try();
      `CHK("start ignored", 1'b0, hit)
      conclude();
   end
endmodule // mdpc_motion_ctrl_tb
